// [hw/cdc_device.sv]
// Purpose: comparator digital control, device end
// Assumes: compare results and port inputs synchronous to ref_clk
// Notes:   timer clock arrives as a sampled level, edges found by compare

// Notes on behaviour
// - hysteresis enable adds input separation
// - outputs offered as timer gate sources
// - sync set latches on timer clock fall
// - latch clock taken after the prescaler
// - timer rises, synced output changes falling
// - separate rising and falling edge detectors
// - enabled edge sets sticky interrupt flag
// - software sets all enables for interrupts
// - software clears flag; new edge wins
// - polarity or enable change triggers detectors
// - positive select picks pin, dac, ref, ground
// - disabled comparator disconnects all inputs
// - negative select low bit picks one of two pins
// - software sets analog and input direction
// - outputs go to shutdown and out pins
// - software checks output after initialization
// - analog pins read zero on port read
// - output high when plus exceeds minus
// - pin driven only when oe, dir, enabled
module cdc_device (
    input  wire logic                ref_clk,
    input  wire logic                rst_n,
    cdc_if.device                    lnk,
    // compare result for each positive source vs each negative pin
    input  wire logic [15:0]         cmp_gt,
    input  wire logic [cdc_pkg::PIN_W-1:0] port_pins_in,
    input  wire logic [cdc_pkg::PIN_W-1:0] analog_select_reg,
    output logic [cdc_pkg::PIN_W-1:0]      port_read_q,
    output logic                     comparator_one_out_pin,
    output logic                     comparator_one_out_oe,
    output logic                     comparator_two_out_pin,
    output logic                     comparator_two_out_oe
);
    import cdc_pkg::*;

    logic [NUM_CMP-1:0] raw_w;
    logic [NUM_CMP-1:0] out_q;
    logic [NUM_CMP-1:0] prev_q;
    logic [NUM_CMP-1:0] sync_q;
    logic [NUM_CMP-1:0] tclk_q;
    logic [NUM_CMP-1:0] flag_q;
    logic [NUM_CMP-1:0] rise_w;
    logic [NUM_CMP-1:0] fall_w;
    logic [NUM_CMP-1:0] pin_q;

    genvar g;
    generate
        for (g = 0; g < NUM_CMP; g++) begin : g_cmp
            cdc_ctrl_type c;
            logic         gt_w;
            logic         tfall_w;
            assign c = lnk.ctrl[g];
            // pick the compare for chosen sources; off when disabled
            assign gt_w = c.comparator_enable &
                cmp_gt[g*8 + {c.positive_input_select,
                              c.negative_input_select[0]}
                       ^ 4'h0];
            // polarity applied even while disabled so it can fire edges
            assign raw_w[g] = gt_w ^ c.output_polarity;
            assign lnk.hysteresis_on[g] =
                c.comparator_enable & c.hysteresis_enable;
            assign lnk.inputs_connected[g] = c.comparator_enable;
            // falling edge of prescaled timer clock
            assign tfall_w = tclk_q[g] & ~lnk.timer_clk_pre[g];
            assign rise_w[g] = raw_w[g] & ~prev_q[g];
            assign fall_w[g] = ~raw_w[g] & prev_q[g];
            // gate source: latched or straight
            assign lnk.timer_gate[g] = c.output_sync_enable ?
                sync_q[g] : out_q[g];

            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    out_q[g]  <= RST_OUT;
                    prev_q[g] <= RST_OUT;
                    sync_q[g] <= RST_OUT;
                    tclk_q[g] <= RST_OUT;
                    flag_q[g] <= RST_OUT;
                    pin_q[g]  <= RST_OUT;
                end else begin
                    out_q[g]  <= raw_w[g];
                    prev_q[g] <= raw_w[g];
                    tclk_q[g] <= lnk.timer_clk_pre[g];
                    // latch the settled output, not a compare that
                    // moves in the same cycle as the clock fall
                    if (tfall_w) begin
                        sync_q[g] <= out_q[g];
                    end
                    // set beats clear
                    if ((rise_w[g] & c.rising_edge_irq_enable) |
                        (fall_w[g] & c.falling_edge_irq_enable)) begin
                        flag_q[g] <= 1'h1;
                    end else if (lnk.irq_clear[g]) begin
                        flag_q[g] <= 1'h0;
                    end
                    pin_q[g] <= out_q[g];
                end
            end
        end
    endgenerate

    assign lnk.comparator_output_bit = out_q;
    assign lnk.comparator_irq_flag   = flag_q;
    assign lnk.shutdown_src          = out_q;

    // output pins: oe overrides port latch
    assign comparator_one_out_pin = pin_q[0];
    assign comparator_two_out_pin = pin_q[1];
    assign comparator_one_out_oe  = lnk.ctrl[0].output_pin_enable &
        ~lnk.pin_dir_in[0] & lnk.ctrl[0].comparator_enable;
    assign comparator_two_out_oe  = lnk.ctrl[1].output_pin_enable &
        ~lnk.pin_dir_in[1] & lnk.ctrl[1].comparator_enable;

    // port read: analog pins return zero
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            port_read_q <= '0;
        end else begin
            port_read_q <= port_pins_in & ~analog_select_reg;
        end
    end
endmodule

// [hw/cdc_pkg.sv]
// Purpose: shared constants and types for the comparator digital control
// Assumes: one clock, ref_clk, 250 MHz; two comparators
// Notes:   analog levels are modelled by a digital compare result per source pair, eight per channel
package cdc_pkg;
    localparam int NUM_CMP = 2;
    localparam int SEL_W   = 2;
    localparam int PIN_W   = 4;

    // positive input sources
    localparam logic [1:0] PSEL_PIN  = 2'h0;
    localparam logic [1:0] PSEL_DAC  = 2'h1;
    localparam logic [1:0] PSEL_REF2 = 2'h2;
    localparam logic [1:0] PSEL_GND  = 2'h3;

    // reset values of control bits
    localparam logic RST_ENABLE   = 1'h0;
    localparam logic RST_POLARITY = 1'h0;
    localparam logic RST_SPEED    = 1'h1;
    localparam logic RST_HYST     = 1'h0;
    localparam logic RST_SYNC     = 1'h0;
    localparam logic RST_OUT      = 1'h0;
    localparam logic [1:0] RST_SEL = 2'h0;
    localparam logic RST_PORT_ZERO = 1'h0;

    // per-comparator control word
    typedef struct packed {
        logic             comparator_enable;
        logic             output_polarity;
        logic             speed_power_select;
        logic             hysteresis_enable;
        logic             output_sync_enable;
        logic             output_pin_enable;
        logic             rising_edge_irq_enable;
        logic             falling_edge_irq_enable;
        logic [SEL_W-1:0] positive_input_select;
        logic [SEL_W-1:0] negative_input_select;
    } cdc_ctrl_type;
endpackage

// [hw/cdc_if.sv]
// Purpose: link between comparator control and its timer/PWM/software partner
// Assumes: all signals synchronous to ref_clk
// Notes:   analog compare results enter as one bit per source pair
interface cdc_if (
    input wire logic ref_clk,
    input wire logic rst_n
);
    import cdc_pkg::*;
    cdc_ctrl_type               ctrl [NUM_CMP];
    logic [NUM_CMP-1:0]         irq_clear;
    logic [NUM_CMP-1:0]         timer_clk_pre;
    logic [NUM_CMP-1:0]         pin_dir_in;
    logic [NUM_CMP-1:0]         comparator_output_bit;
    logic [NUM_CMP-1:0]         comparator_irq_flag;
    logic [NUM_CMP-1:0]         timer_gate;
    logic [NUM_CMP-1:0]         shutdown_src;
    logic [NUM_CMP-1:0]         hysteresis_on;
    logic [NUM_CMP-1:0]         inputs_connected;

    modport device (
        input  ctrl, irq_clear, timer_clk_pre, pin_dir_in,
        output comparator_output_bit, comparator_irq_flag, timer_gate,
               shutdown_src, hysteresis_on, inputs_connected
    );
    modport partner (
        output ctrl, irq_clear, timer_clk_pre, pin_dir_in,
        input  comparator_output_bit, comparator_irq_flag, timer_gate,
               shutdown_src, hysteresis_on, inputs_connected
    );
endinterface

// [hw/cdc_partner.sv]
// Purpose: partner end: control registers, timer gate and pwm shutdown
// Assumes: software writes arrive as one-cycle strobes
// Notes:   timer counts on rising edge of its prescaled clock
module cdc_partner (
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    cdc_if.partner                     lnk,
    input  wire logic [1:0]            wr_sel,
    input  wire cdc_pkg::cdc_ctrl_type wr_data,
    input  wire logic [1:0]            clr_flag,
    input  wire logic [1:0]            dir_in,
    input  wire logic [1:0]            timer_tick,
    input  wire logic [1:0]            gate_select,
    output logic [15:0]                timer_count_q,
    output logic                       pwm_shutdown_q
);
    import cdc_pkg::*;

    cdc_ctrl_type ctrl_q [NUM_CMP];
    logic [1:0]   tick_q;
    logic         gate_w;
    logic         trise_w;

    // software side requests
    assign lnk.ctrl          = ctrl_q;
    assign lnk.irq_clear     = clr_flag;
    assign lnk.pin_dir_in    = dir_in;
    assign lnk.timer_clk_pre = timer_tick;
    assign gate_w  = lnk.timer_gate[gate_select[0]];
    assign trise_w = timer_tick[gate_select[0]] &
                     ~tick_q[gate_select[0]];

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_CMP; i++) begin
                ctrl_q[i] <= '{RST_ENABLE, RST_POLARITY, RST_SPEED,
                    RST_HYST, RST_SYNC, 1'h0, 1'h0, 1'h0,
                    RST_SEL, RST_SEL};
            end
            tick_q         <= '0;
            timer_count_q  <= '0;
            pwm_shutdown_q <= 1'h0;
        end else begin
            for (int i = 0; i < NUM_CMP; i++) begin
                if (wr_sel[i]) begin
                    ctrl_q[i] <= wr_data;
                end
            end
            tick_q <= timer_tick;
            if (trise_w & gate_w) begin
                timer_count_q <= timer_count_q + 16'h1;
            end
            pwm_shutdown_q <= |lnk.shutdown_src;
        end
    end
endmodule

// [bench/cdc_assertions.sv]
// Purpose: link checks between the two comparator control ends
// Assumes: one clock, ref_clk; rst_n async active low
// Notes:   channel 0 is watched, channel 1 shares the same logic
module cdc_assertions (
    input wire logic             ref_clk,
    input wire logic             rst_n,
    input cdc_pkg::cdc_ctrl_type ctrl [2],
    input wire logic [1:0]       irq_clear,
    input wire logic [1:0]       timer_clk_pre,
    input wire logic [1:0]       comparator_output_bit,
    input wire logic [1:0]       comparator_irq_flag,
    input wire logic [1:0]       timer_gate,
    input wire logic [1:0]       hysteresis_on,
    input wire logic [1:0]       inputs_connected
);
    import cdc_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // channel 0 shorthands
    wire out0 = comparator_output_bit[0];
    wire flg0 = comparator_irq_flag[0];
    wire en0  = ctrl[0].comparator_enable;
    // input, edge, flag and gate relations
    property p_hys; en0 |-> hysteresis_on[0] == ctrl[0].hysteresis_enable;
    endproperty
    a_hys: assert property (p_hys) else $error("hysteresis wrong");
    property p_conn; inputs_connected[0] == en0; endproperty
    a_conn: assert property (p_conn) else $error("inputs wrong");
    property p_rise;
        $rose(out0) && $past(ctrl[0].rising_edge_irq_enable) |-> flg0;
    endproperty
    a_rise: assert property (p_rise) else $error("no flag");
    property p_fall;
        $fell(out0) && $past(ctrl[0].falling_edge_irq_enable) |-> flg0;
    endproperty
    a_fall: assert property (p_fall) else $error("no fall flag");
    property p_hold; flg0 && !irq_clear[0] |=> flg0; endproperty
    a_hold: assert property (p_hold) else $error("flag lost");
    property p_clear; $past(irq_clear[0]) && $stable(out0) |-> !flg0;
    endproperty
    a_clear: assert property (p_clear) else $error("flag kept");
    property p_nosync;
        !ctrl[0].output_sync_enable |-> timer_gate[0] == out0;
    endproperty
    a_nosync: assert property (p_nosync) else $error("gate wrong");
    property p_sync; (ctrl[0].output_sync_enable &&
        !$fell(timer_clk_pre[0])) [*3] |-> $stable(timer_gate[0]);
    endproperty
    a_sync: assert property (p_sync) else $error("gate moved");
    property p_dis;
        !en0 |=> out0 == $past(ctrl[0].output_polarity);
    endproperty
    a_dis: assert property (p_dis) else $error("off output wrong");
endmodule

// [bench/tb_comparator_digital_control.sv]
// Purpose: bench for both comparator control ends joined by cdc_if
// Assumes: inputs change on the falling edge of ref_clk
// Notes:   one-hot compare results make a wrong select read low
module tb_comparator_digital_control;
    timeunit 1ns;
    timeprecision 1ps;
    import cdc_pkg::*;
    logic         ref_clk = 1'b0;
    logic         rst_n = 1'b0;
    logic [15:0]  cmp_gt = 16'h0;
    logic [3:0]   port_read_q;
    logic [1:0]   wr_sel = 2'h0;
    logic [1:0]   clr_flag = 2'h0;
    logic [1:0]   dir_in = 2'h3;
    logic [1:0]   tick = 2'h0;
    cdc_ctrl_type wr_data = '0;
    logic         pin1, oe1, pin2, oe2, seen;
    logic [15:0]  tcnt;
    logic         pwm;
    logic [1:0]   gsel = 2'h0;
    int           n_mismatch = 0;
    int           cmp_count = 0;
    always #2 ref_clk = ~ref_clk;
    // both ends and the link checker
    cdc_if lnk (.ref_clk(ref_clk), .rst_n(rst_n));
    wire out0 = lnk.comparator_output_bit[0];
    wire flag = lnk.comparator_irq_flag[0];
    cdc_device u_cdc_device (.ref_clk(ref_clk), .rst_n(rst_n), .lnk(lnk),
        .cmp_gt(cmp_gt), .port_pins_in(4'hf), .analog_select_reg(4'h5),
        .port_read_q(port_read_q), .comparator_one_out_pin(pin1),
        .comparator_one_out_oe(oe1), .comparator_two_out_pin(pin2),
        .comparator_two_out_oe(oe2));
    cdc_partner u_cdc_partner (.ref_clk(ref_clk), .rst_n(rst_n), .lnk(lnk),
        .wr_sel(wr_sel), .wr_data(wr_data), .clr_flag(clr_flag),
        .dir_in(dir_in), .timer_tick(tick), .gate_select(gsel),
        .timer_count_q(tcnt), .pwm_shutdown_q(pwm));
    cdc_assertions u_cdc_assertions (.ref_clk(ref_clk), .rst_n(rst_n),
        .ctrl(lnk.ctrl), .irq_clear(lnk.irq_clear),
        .timer_clk_pre(lnk.timer_clk_pre),
        .comparator_output_bit(lnk.comparator_output_bit),
        .comparator_irq_flag(lnk.comparator_irq_flag),
        .timer_gate(lnk.timer_gate), .hysteresis_on(lnk.hysteresis_on),
        .inputs_connected(lnk.inputs_connected));
    // stepping, control write, compare, flag clear, verdict
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic wr(input int c, input logic [11:0] b);
        cyc(1);
        wr_sel = 2'(1 << c);
        wr_data = cdc_ctrl_type'(b);
        cyc(1);
        wr_sel = 2'h0;
        cyc(2);
    endtask
    task automatic chk(input string nm, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s exp %b got %b", nm, e, g);
        end
    endtask
    task automatic clr();
        clr_flag[0] = 1'b1;
        cyc(2);
        clr_flag[0] = 1'b0;
        cyc(2);
    endtask
    task automatic complete_run();
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // hang guard
    initial begin
        cyc(20000);
        n_mismatch++;
        complete_run();
    end
    // main sequence
    initial begin
        cyc(10);
        rst_n = 1'b1;
        cyc(2);
        for (int i = 0; i < 4; i++) chk("port", 1'(i % 2), port_read_q[i]);
        chk("pwm idle", 1'b0, pwm);
        for (int c = 0; c < 2; c++) for (int p = 0; p < 4; p++)
            for (int n = 0; n < 4; n++) begin
                cmp_gt = 16'h1 << (c * 8 + p * 2 + n % 2);
                wr(c, 12'h800 | 12'(p * 4 + n) | (n > 1 ? 12'h100 : 12'h0)
                    | (n == 3 ? 12'h400 : 12'h0));
                chk("out", n != 3, lnk.comparator_output_bit[c]);
                chk("hys", n > 1, lnk.hysteresis_on[c]);
            end
        cmp_gt = 16'h0;
        wr(0, 12'h820);
        clr();
        cmp_gt[0] = 1'b1;
        cyc(7);
        chk("rise", 1'b1, flag);
        clr();
        chk("clear", 1'b0, flag);
        cmp_gt[0] = 1'b0;
        cyc(2);
        chk("no fall", 1'b0, flag);
        wr(0, 12'h810);
        cmp_gt[0] = 1'b1;
        cyc(2);
        chk("no rise", 1'b0, flag);
        cmp_gt[0] = 1'b0;
        cyc(2);
        chk("fall", 1'b1, flag);
        wr(0, 12'h820);
        clr_flag[0] = 1'b1;
        cyc(3);
        cmp_gt[0] = 1'b1;
        seen = 1'b0;
        repeat (4) begin
            cyc(1);
            seen = seen | flag;
        end
        clr_flag[0] = 1'b0;
        chk("set wins", 1'b1, seen);
        wr(0, 12'h020);
        clr();
        chk("conn", 1'b0, lnk.inputs_connected[0]);
        wr(0, 12'h420);
        chk("pol irq", 1'b1, flag);
        dir_in = 2'h0;
        wr(0, 12'h840);
        chk("pin", 1'b1, pin1);
        chk("oe", 1'b1, oe1);
        dir_in = 2'h3;
        cyc(2);
        chk("oe dir", 1'b0, oe1);
        dir_in = 2'h0;
        wr(0, 12'h040);
        chk("oe off", 1'b0, oe1);
        wr(0, 12'h800);
        chk("gate", 1'b1, lnk.timer_gate[0]);
        cmp_gt[0] = 1'b0;
        wr(0, 12'h880);
        for (int k = 0; k < 4; k++) begin
            tick[0] = ~tick[0];
            cmp_gt[0] = (k == 2);
            cyc(3);
            chk("sync", 1'(k == 3), lnk.timer_gate[0]);
        end
        // timer counts on a clock rise while its chosen gate is high
        tick[0] = 1'b1;
        cyc(2);
        chk("count", 1'b1, tcnt == 16'h1);
        gsel = 2'h1;
        tick[1] = 1'b1;
        cyc(2);
        chk("count two", 1'b1, tcnt == 16'h2);
        chk("pwm", 1'b1, pwm);
        chk("pin2", 1'b1, pin2);
        chk("oe2", 1'b0, oe2);
        complete_run();
    end
endmodule
